// [hdl/codec_analog_pkg.sv]
// Constants, register map and types for the codec analog control bank.
package codec_analog_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MUTE  = 8'h6B;
  localparam logic [7:0] ADDR_ADC1  = 8'h71;
  localparam logic [7:0] ADDR_ADC2  = 8'h72;
  localparam logic [7:0] ADDR_PLAY  = 8'h73;
  localparam logic [7:0] ADDR_BIAS  = 8'h74;
  localparam logic [7:0] ADDR_BOOST = 8'h76;
  localparam logic [7:0] ADDR_FEAMP = 8'h77;
  localparam logic [7:0] ADDR_GAIN  = 8'h7E;

  // ----------------------------------------------------------------
  // Reset values, writable masks and fixed read-only bits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_MUTE  = 16'h0000;
  localparam logic [15:0] RST_ADC1  = 16'h0011;
  localparam logic [15:0] RST_ADC2  = 16'h0020;
  localparam logic [15:0] RST_PLAY  = 16'h0008;
  localparam logic [15:0] RST_BIAS  = 16'h0006;
  localparam logic [15:0] RST_BOOST = 16'h0000;
  localparam logic [15:0] RST_FEAMP = 16'h0000;
  localparam logic [15:0] RST_GAIN  = 16'h0000;

  localparam logic [15:0] MASK_MUTE  = 16'h000F;
  localparam logic [15:0] MASK_ADC1  = 16'h0040;
  localparam logic [15:0] MASK_ADC2  = 16'hC3C3;
  localparam logic [15:0] MASK_PLAY  = 16'hFF1C;
  localparam logic [15:0] MASK_BIAS  = 16'h1C07;
  localparam logic [15:0] MASK_BOOST = 16'h02BD;
  localparam logic [15:0] MASK_FEAMP = 16'h03FF;
  localparam logic [15:0] MASK_GAIN  = 16'h003F;

  // Bits that always read back their reset level and ignore writes.
  localparam logic [15:0] FIXED_ADC1 = 16'h0011;
  localparam logic [15:0] FIXED_ADC2 = 16'h0020;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MIC_DET_PD_BIT   = 6;
  localparam int LEFT_PWR_BIT     = 0;
  localparam int RIGHT_PWR_BIT    = 1;
  localparam int CONV_BIAS_LSB    = 6;
  localparam int CONV_REF_LSB     = 8;
  localparam int RIGHT_BOOST_BIT  = 14;
  localparam int LEFT_BOOST_BIT   = 15;
  localparam int FULLSCALE_LSB    = 2;
  localparam int SMOOTH_BIT       = 4;
  localparam int SKEW_LSB         = 8;
  localparam int SMOOTH_SPARE_BIT = 11;
  localparam int DAC_EN_LSB       = 12;
  localparam int DAC_CLK_LSB      = 14;
  localparam int BIAS_LVL_LSB     = 0;
  localparam int BIAS_PWR_BIT     = 10;
  localparam int LOW_NOISE_BIT    = 11;
  localparam int BIAS_RES_BIT     = 12;
  localparam int AUTO_REL_BIT     = 0;
  localparam int LIMIT_LSB        = 2;
  localparam int MODE_BIT         = 4;
  localparam int BOOST_DIS_BIT    = 5;
  localparam int CHARGE_EN_BIT    = 7;
  localparam int STATUS_BIT       = 8;
  localparam int PRECHG_BIT0      = 9;
  localparam int CLEAR_BIT        = 15;
  localparam int RIGHT_MODE_LSB   = 0;
  localparam int LEFT_MODE_LSB    = 4;
  localparam int PRECHG_LSB       = 8;
  localparam logic [5:0] GAIN_MAX = 6'h25;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Cycle counts at a 100 MHz clock, kept integral to avoid rounding in real arithmetic.
  localparam int  DEBOUNCE_CYCLES    = 1630;
  localparam int  RELEASE_CYCLES_DEF = 163000;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_DEBOUNCE = 3'b010,
    ST_SHUT     = 3'b100
  } short_state_t;

endpackage : codec_analog_pkg

// [hdl/codec_analog_control_bank.sv]
// Analog control register bank with headset short-circuit shutdown logic.
`timescale 1ns/1ps

module codec_analog_control_bank #(
  parameter int RELEASE_CYCLES = codec_analog_pkg::RELEASE_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic        shortDetect,
  output logic [15:0]      regRdData,
  output logic             irqOut,
  output logic             driverShutdown,
  output logic [3:0]       micInputMute,
  output logic             micDetectPowerDown,
  output logic             leftAmpBiasBoost,
  output logic             rightAmpBiasBoost,
  output logic [1:0]       converterBiasSelect,
  output logic [1:0]       converterReferenceSelect,
  output logic             leftConverterPower,
  output logic             rightConverterPower,
  output logic [1:0]       dacEnable,
  output logic [1:0]       dacClockEnable,
  output logic             smoothingEnable,
  output logic signed [3:0] clockSkewNs,
  output logic [1:0]       playbackFullscaleSelect,
  output logic             biasGroundResistorEnable,
  output logic             microphoneBiasGenerator,
  output logic             biasLowNoise,
  output logic [2:0]       microphoneBiasLevel,
  output logic [1:0]       shortCurrentLimit,
  output logic             boostDriverDisable,
  output logic             chargeInputEnable,
  output logic             micPositiveCharge,
  output logic             micNegativeCharge,
  output logic [3:0]       leftAmpMode,
  output logic [3:0]       rightAmpMode,
  output logic [5:0]       leftAmpGain
);
  import codec_analog_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0]  muteQ, adc1Q, adc2Q, playQ, biasQ, boostQ, feampQ, gainQ;
  logic [15:0]  rdDataQ;
  logic         clearPulse;
  logic         shortShutdownFlag;
  short_state_t stateQ, stateD;
  logic [10:0]  debCntQ;
  logic [17:0]  relCntQ;
  logic         irqQ;
  logic         shutQ;
  logic signed [3:0] skewQ;
  logic         shortAutoReleaseEnable;
  logic         shortShutdownMode;
  logic [1:0]   prechgQ;

  function automatic logic [15:0] merge(input logic [15:0] oldV, input logic [15:0] newV,
                                        input logic [15:0] mask);
    merge = (oldV & ~mask) | (newV & mask);
  endfunction : merge

  function automatic logic signed [3:0] skewDecode(input logic [2:0] code);
    case (code)
      3'b000:  skewDecode = 4'sh0;
      3'b001:  skewDecode = 4'sh1;
      3'b010:  skewDecode = 4'sh2;
      3'b100:  skewDecode = 4'sh4;
      3'b110:  skewDecode = -4'sh2;
      3'b111:  skewDecode = -4'sh1;
      default: skewDecode = -4'sh3;
    endcase
  endfunction : skewDecode

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      muteQ  <= RST_MUTE;
      adc1Q  <= RST_ADC1;
      adc2Q  <= RST_ADC2;
      playQ  <= RST_PLAY;
      biasQ  <= RST_BIAS;
      boostQ <= RST_BOOST;
      feampQ <= RST_FEAMP;
      gainQ  <= RST_GAIN;
    end else if (regWrEn) begin
      if (regAddr == ADDR_MUTE) begin
        muteQ <= merge(muteQ, regWrData, MASK_MUTE);
      end else if (regAddr == ADDR_ADC1) begin
        adc1Q <= merge(adc1Q, regWrData, MASK_ADC1);
      end else if (regAddr == ADDR_ADC2) begin
        adc2Q <= merge(adc2Q, regWrData, MASK_ADC2);
      end else if (regAddr == ADDR_PLAY) begin
        playQ <= merge(playQ, regWrData, MASK_PLAY);
      end else if (regAddr == ADDR_BIAS) begin
        biasQ <= merge(biasQ, regWrData, MASK_BIAS);
      end else if (regAddr == ADDR_BOOST) begin
        boostQ <= merge(boostQ, regWrData, MASK_BOOST);
      end else if (regAddr == ADDR_FEAMP) begin
        feampQ <= merge(feampQ, regWrData, MASK_FEAMP);
      end else if (regAddr == ADDR_GAIN) begin
        // Codes past the top step saturate at the top step.
        if (regWrData[5:0] > GAIN_MAX) begin
          gainQ <= {10'h000, GAIN_MAX};
        end else begin
          gainQ <= merge(gainQ, regWrData, MASK_GAIN);
        end
      end
    end
  end

  assign clearPulse = regWrEn && (regAddr == ADDR_BOOST) && regWrData[CLEAR_BIT];
  assign shortAutoReleaseEnable = boostQ[AUTO_REL_BIT];
  assign shortShutdownMode      = boostQ[MODE_BIT];
  assign shortShutdownFlag      = (stateQ == ST_SHUT);

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdDataQ <= 16'h0000;
    end else if (regRdEn) begin
      if (regAddr == ADDR_MUTE) begin
        rdDataQ <= muteQ;
      end else if (regAddr == ADDR_ADC1) begin
        rdDataQ <= adc1Q;
      end else if (regAddr == ADDR_ADC2) begin
        rdDataQ <= adc2Q;
      end else if (regAddr == ADDR_PLAY) begin
        rdDataQ <= playQ;
      end else if (regAddr == ADDR_BIAS) begin
        rdDataQ <= biasQ;
      end else if (regAddr == ADDR_BOOST) begin
        rdDataQ <= boostQ | (16'h0001 << STATUS_BIT) & {16{shortShutdownFlag}};
      end else if (regAddr == ADDR_FEAMP) begin
        rdDataQ <= feampQ;
      end else if (regAddr == ADDR_GAIN) begin
        rdDataQ <= gainQ;
      end else begin
        rdDataQ <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded clock skew
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      skewQ <= 4'sh0;
    end else begin
      skewQ <= skewDecode(playQ[SKEW_LSB +: 3]);
    end
  end

  // ----------------------------------------------------------------
  // Short-circuit shutdown state machine
  // ----------------------------------------------------------------
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_IDLE: begin
        if (!shortShutdownMode && shortDetect) begin
          stateD = ST_DEBOUNCE;
        end
      end
      ST_DEBOUNCE: begin
        if (shortShutdownMode || !shortDetect) begin
          stateD = ST_IDLE;
        end else if (debCntQ == 11'(DEBOUNCE_CYCLES - 1)) begin
          stateD = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (!shortAutoReleaseEnable && clearPulse && !shortDetect) begin
          stateD = ST_IDLE;
        end else if (shortAutoReleaseEnable && !shortDetect &&
                     relCntQ == 18'(RELEASE_CYCLES - 1)) begin
          stateD = ST_IDLE;
        end
      end
      default: stateD = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      debCntQ <= 11'h001;
    end else if (stateQ == ST_DEBOUNCE && shortDetect) begin
      debCntQ <= debCntQ + 11'h001;
    end else begin
      debCntQ <= 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      relCntQ <= 18'h00000;
    end else if (stateQ == ST_SHUT && shortAutoReleaseEnable && !shortDetect) begin
      relCntQ <= relCntQ + 18'h00001;
    end else begin
      relCntQ <= 18'h00000;
    end
  end

  // A new shutdown event wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      irqQ <= 1'b0;
    end else if (stateQ == ST_DEBOUNCE && stateD == ST_SHUT) begin
      irqQ <= 1'b1;
    end else if (clearPulse && (shortAutoReleaseEnable || !shortDetect)) begin
      irqQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shutQ <= 1'b0;
    end else if (shortShutdownMode) begin
      shutQ <= shortDetect || stateD == ST_SHUT;
    end else begin
      shutQ <= stateD == ST_SHUT;
    end
  end

  // Precharge requests only reach the inputs while charging is enabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      prechgQ <= 2'b00;
    end else begin
      prechgQ <= feampQ[PRECHG_LSB +: 2] & {2{boostQ[CHARGE_EN_BIT]}};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData                = rdDataQ;
  assign irqOut                   = irqQ;
  assign driverShutdown           = shutQ;
  assign clockSkewNs              = skewQ;
  assign micInputMute             = muteQ[3:0];
  assign micDetectPowerDown       = adc1Q[MIC_DET_PD_BIT];
  assign leftAmpBiasBoost         = adc2Q[LEFT_BOOST_BIT];
  assign rightAmpBiasBoost        = adc2Q[RIGHT_BOOST_BIT];
  assign converterBiasSelect      = adc2Q[CONV_BIAS_LSB +: 2];
  assign converterReferenceSelect = adc2Q[CONV_REF_LSB +: 2];
  assign leftConverterPower       = adc2Q[LEFT_PWR_BIT];
  assign rightConverterPower      = adc2Q[RIGHT_PWR_BIT];
  assign dacEnable                = playQ[DAC_EN_LSB +: 2];
  assign dacClockEnable           = playQ[DAC_CLK_LSB +: 2];
  assign smoothingEnable          = playQ[SMOOTH_BIT];
  assign playbackFullscaleSelect  = playQ[FULLSCALE_LSB +: 2];
  assign biasGroundResistorEnable = biasQ[BIAS_RES_BIT];
  assign microphoneBiasGenerator  = biasQ[BIAS_PWR_BIT];
  assign biasLowNoise             = biasQ[LOW_NOISE_BIT];
  assign microphoneBiasLevel      = biasQ[BIAS_LVL_LSB +: 3];
  assign shortCurrentLimit        = boostQ[LIMIT_LSB +: 2];
  assign boostDriverDisable       = boostQ[BOOST_DIS_BIT];
  assign chargeInputEnable        = boostQ[CHARGE_EN_BIT];
  assign micPositiveCharge        = prechgQ[0];
  assign micNegativeCharge        = prechgQ[1];
  assign leftAmpMode              = feampQ[LEFT_MODE_LSB +: 4];
  assign rightAmpMode             = feampQ[RIGHT_MODE_LSB +: 4];
  assign leftAmpGain              = gainQ[5:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_detect_write;
    @(posedge clk) disable iff (rst)
      regWrEn && regAddr == ADDR_ADC1 |=> micDetectPowerDown == $past(regWrData[MIC_DET_PD_BIT]);
  endproperty
  a_detect_write: assert property (p_detect_write) else $error("Detect power-down bit not written.");

  property p_clear_not_held;
    @(posedge clk) disable iff (rst)
      regRdEn && regAddr == ADDR_BOOST |=> regRdData[CLEAR_BIT] == 1'b0;
  endproperty
  a_clear_not_held: assert property (p_clear_not_held) else $error("Clear bit held a value.");

  property p_debounce_length;
    @(posedge clk) disable iff (rst)
      $rose(shortShutdownFlag) |-> $past(debCntQ) == 11'(DEBOUNCE_CYCLES - 1) && $past(shortDetect);
  endproperty
  a_debounce_length: assert property (p_debounce_length) else $error("Shutdown before full debounce.");

  property p_mode1_immediate;
    @(posedge clk) disable iff (rst)
      shortShutdownMode && shortDetect |=> driverShutdown;
  endproperty
  a_mode1_immediate: assert property (p_mode1_immediate) else $error("Mode 1 shutdown not immediate.");

  property p_irq_source;
    @(posedge clk) disable iff (rst)
      $rose(irqOut) |-> $past(stateQ) == ST_DEBOUNCE && !$past(shortShutdownMode);
  endproperty
  a_irq_source: assert property (p_irq_source) else $error("Interrupt raised without debounce.");

  property p_flag_hold_manual;
    @(posedge clk) disable iff (rst)
      shortShutdownFlag && !shortAutoReleaseEnable && !clearPulse |=> shortShutdownFlag;
  endproperty
  a_flag_hold_manual: assert property (p_flag_hold_manual) else $error("Flag dropped without clear.");

  property p_release_time;
    @(posedge clk) disable iff (rst)
      $fell(shortShutdownFlag) && $past(shortAutoReleaseEnable) |-> $past(relCntQ) == 18'(RELEASE_CYCLES - 1);
  endproperty
  a_release_time: assert property (p_release_time) else $error("Auto release at wrong time.");

  property p_irq_hold;
    @(posedge clk) disable iff (rst) irqOut && !clearPulse |=> irqOut;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("Interrupt dropped without clear.");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      regRdEn && regAddr == ADDR_ADC2 |=> (regRdData & ~(MASK_ADC2 | FIXED_ADC2)) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero.");

  property p_gain_max;
    @(posedge clk) disable iff (rst) leftAmpGain <= GAIN_MAX;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("Gain code above top step.");

  property p_skew_decode;
    @(posedge clk) disable iff (rst)
      $past(playQ[SKEW_LSB +: 3]) == 3'b101 |-> clockSkewNs == -4'sh3;
  endproperty
  a_skew_decode: assert property (p_skew_decode) else $error("Skew code 101 misdecoded.");

endmodule : codec_analog_control_bank

// [bench/tb.sv]
// Self-checking testbench for the codec analog control bank.
`timescale 1ns/1ps

module tb;
  import codec_analog_pkg::*;

  localparam int REL = 50;

  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic [7:0]  regAddr     = 8'h00;
  logic [15:0] regWrData   = 16'h0000;
  logic        regWrEn     = 1'b0;
  logic        regRdEn     = 1'b0;
  logic        shortDetect = 1'b0;
  logic        rdPend      = 1'b0;
  logic [15:0] regRdData;
  logic        irqOut, driverShutdown, micDetectPowerDown, leftAmpBiasBoost, rightAmpBiasBoost;
  logic        leftConverterPower, rightConverterPower, smoothingEnable, biasGroundResistorEnable;
  logic        microphoneBiasGenerator, biasLowNoise, boostDriverDisable, chargeInputEnable;
  logic        micPositiveCharge, micNegativeCharge;
  logic [1:0]  converterBiasSelect, converterReferenceSelect, dacEnable, dacClockEnable;
  logic [1:0]  playbackFullscaleSelect, shortCurrentLimit;
  logic [2:0]  microphoneBiasLevel;
  logic [3:0]  micInputMute, leftAmpMode, rightAmpMode;
  logic signed [3:0] clockSkewNs;
  logic [5:0]  leftAmpGain;
  logic [15:0] expQ[$];
  logic [15:0] dv [8];
  logic [7:0]  addrs [8] = '{ADDR_MUTE, ADDR_ADC1, ADDR_ADC2, ADDR_PLAY, ADDR_BIAS, ADDR_BOOST, ADDR_FEAMP, ADDR_GAIN};
  logic [15:0] rsts [8]  = '{RST_MUTE, RST_ADC1, RST_ADC2, RST_PLAY, RST_BIAS, RST_BOOST, RST_FEAMP, RST_GAIN};
  logic [15:0] masks [8] = '{MASK_MUTE, MASK_ADC1, MASK_ADC2, MASK_PLAY, MASK_BIAS, MASK_BOOST, MASK_FEAMP, MASK_GAIN};
  logic [15:0] fixd [8]  = '{16'h0000, FIXED_ADC1, FIXED_ADC2, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic signed [3:0] skewExp [8] = '{4'sd0, 4'sd1, 4'sd2, -4'sd3, 4'sd4, -4'sd3, -4'sd2, -4'sd1};
  int          error_cnt  = 0;
  int          num_checks = 0;

  always #5 clk = ~clk;

  codec_analog_control_bank #(.RELEASE_CYCLES(REL)) DUT (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .shortDetect(shortDetect), .regRdData(regRdData), .irqOut(irqOut), .driverShutdown(driverShutdown),
    .micInputMute(micInputMute), .micDetectPowerDown(micDetectPowerDown), .leftAmpBiasBoost(leftAmpBiasBoost),
    .rightAmpBiasBoost(rightAmpBiasBoost), .converterBiasSelect(converterBiasSelect),
    .converterReferenceSelect(converterReferenceSelect), .leftConverterPower(leftConverterPower),
    .rightConverterPower(rightConverterPower), .dacEnable(dacEnable), .dacClockEnable(dacClockEnable),
    .smoothingEnable(smoothingEnable), .clockSkewNs(clockSkewNs), .playbackFullscaleSelect(playbackFullscaleSelect),
    .biasGroundResistorEnable(biasGroundResistorEnable), .microphoneBiasGenerator(microphoneBiasGenerator),
    .biasLowNoise(biasLowNoise), .microphoneBiasLevel(microphoneBiasLevel), .shortCurrentLimit(shortCurrentLimit),
    .boostDriverDisable(boostDriverDisable), .chargeInputEnable(chargeInputEnable),
    .micPositiveCharge(micPositiveCharge), .micNegativeCharge(micNegativeCharge), .leftAmpMode(leftAmpMode),
    .rightAmpMode(rightAmpMode), .leftAmpGain(leftAmpGain)
  );

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data is valid in the cycle after the read strobe is taken.
  always @(posedge clk) rdPend <= regRdEn;
  always @(negedge clk) begin
    if (rdPend) begin
      chk(regRdData, expQ.pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    expQ.push_back(e);
    @(negedge clk);
    regRdEn = 1'b0;
  endtask : rd

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Waits for the driver shutdown level, counting cycles, and checks both bounds, ending the test past the upper one.
  task automatic waitShut(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (driverShutdown !== lvl) begin
      @(negedge clk);
      n++;
      if (n > hi) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, driverShutdown, lvl);
        end_of_test();
      end
    end
    chk(16'(n >= lo), 16'h0001);
  endtask : waitShut

  function automatic logic [15:0] expOf(input int i, input logic [15:0] d);
    logic [15:0] e;
    e = (d & masks[i]) | fixd[i];
    if (addrs[i] == ADDR_BOOST) e[STATUS_BIT] = 1'b0;
    if (addrs[i] == ADDR_GAIN && d[5:0] > GAIN_MAX) e = {10'h000, GAIN_MAX};
    return e;
  endfunction : expOf

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h10A6487E));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(addrs[i], rsts[i]);
    rd(8'h70, 16'h0000);
    $display("Reset values done");
    for (int i = 0; i < 8; i++) begin
      dv[i] = 16'($urandom);
      dv[i][15] = 1'b0;
      wr(addrs[i], dv[i]);
      rd(addrs[i], expOf(i, dv[i]));
    end
    wr(8'h70, 16'hFFFF);
    rd(8'h70, 16'h0000);
    chk(16'({micInputMute, micDetectPowerDown}), 16'({dv[0][3:0], dv[1][6]}));
    chk(16'({leftAmpBiasBoost, rightAmpBiasBoost}), 16'({dv[2][15], dv[2][14]}));
    chk(16'({converterBiasSelect, converterReferenceSelect}), 16'({dv[2][7:6], dv[2][9:8]}));
    chk(16'({leftConverterPower, rightConverterPower}), 16'({dv[2][0], dv[2][1]}));
    chk(16'({dacEnable, dacClockEnable, smoothingEnable}), 16'({dv[3][13:12], dv[3][15:14], dv[3][4]}));
    chk(16'(playbackFullscaleSelect), 16'(dv[3][3:2]));
    chk(16'({biasGroundResistorEnable, microphoneBiasGenerator}), 16'({dv[4][12], dv[4][10]}));
    chk(16'({biasLowNoise, microphoneBiasLevel}), 16'({dv[4][11], dv[4][2:0]}));
    chk(16'({shortCurrentLimit, boostDriverDisable}), 16'({dv[5][3:2], dv[5][5]}));
    chk(16'({leftAmpMode, rightAmpMode}), 16'({dv[6][7:4], dv[6][3:0]}));
    chk(16'(leftAmpGain), expOf(7, dv[7]));
    wr(ADDR_GAIN, 16'h0026);
    rd(ADDR_GAIN, 16'h0025);
    wr(ADDR_GAIN, 16'h0025);
    chk(16'(leftAmpGain), 16'h0025);
    $display("Register access done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_PLAY, 16'(c << SKEW_LSB));
      tick(1);
      chk(16'(clockSkewNs), 16'(skewExp[c]));
    end
    wr(ADDR_BOOST, 16'h0000);
    wr(ADDR_FEAMP, 16'h0300);
    tick(1);
    chk(16'({micPositiveCharge, micNegativeCharge}), 16'h0000);
    wr(ADDR_BOOST, 16'h0080);
    tick(1);
    chk(16'({micPositiveCharge, micNegativeCharge, chargeInputEnable}), 16'h0007);
    $display("Decode and precharge done");
    // Mode 0 without auto release: debounce, refused clear, then clear.
    wr(ADDR_BOOST, 16'h0000);
    shortDetect = 1'b1;
    waitShut(1'b1, 1625, 1640);
    chk(16'(irqOut), 16'h0001);
    rd(ADDR_BOOST, 16'h0100);
    wr(ADDR_BOOST, 16'h8000);
    tick(2);
    chk(16'({irqOut, driverShutdown}), 16'h0003);
    shortDetect = 1'b0;
    tick(100);
    chk(16'({irqOut, driverShutdown}), 16'h0003);
    wr(ADDR_BOOST, 16'h8000);
    tick(1);
    chk(16'({irqOut, driverShutdown}), 16'h0000);
    rd(ADDR_BOOST, 16'h0000);
    // A dropout restarts the debounce count.
    shortDetect = 1'b1;
    tick(1000);
    shortDetect = 1'b0;
    tick(1);
    shortDetect = 1'b1;
    tick(1000);
    chk(16'(driverShutdown), 16'h0000);
    shortDetect = 1'b0;
    $display("Mode 0 done");
    wr(ADDR_BOOST, 16'h0001);
    shortDetect = 1'b1;
    waitShut(1'b1, 1625, 1640);
    shortDetect = 1'b0;
    waitShut(1'b0, REL - 5, REL + 10);
    chk(16'(irqOut), 16'h0001);
    wr(ADDR_BOOST, 16'h8001);
    tick(1);
    chk(16'(irqOut), 16'h0000);
    $display("Auto release done");
    wr(ADDR_BOOST, 16'h0010);
    shortDetect = 1'b1;
    tick(2);
    chk(16'({irqOut, driverShutdown}), 16'h0001);
    rd(ADDR_BOOST, 16'h0010);
    shortDetect = 1'b0;
    tick(2);
    chk(16'(driverShutdown), 16'h0000);
    $display("Mode 1 done");
    tick(2);
    end_of_test();
  end

endmodule : tb
